// ---- bench/rsp_far_end.sv ----
// Far-end serial device model: sends and captures 8-bit frames
`default_nettype none
module rsp_far_end #(
  parameter int BT = 100  // Clocks per bit
) (
  input  wire logic clk,  // System clock
  input  wire logic txd,  // Line from port
  output var  logic rxd   // Line to port, idle mark
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got;    // Last char captured
  logic [7:0] sh;     // Capture shift
  int         n_got;  // Chars captured
  initial begin
    rxd = 1'b1;
    n_got = 0;
  end
  //////////////////////////////////////////////////////////////////////
  // Sender: LSB first; a low stop makes a framing fault on purpose
  task automatic send(input logic [7:0] c, input logic stp);
    rxd = 1'b0;
    repeat (BT) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      rxd = c[i];
      repeat (BT) @(negedge clk);
    end
    rxd = stp;
    repeat (BT) @(negedge clk);
    rxd = 1'b1;
    repeat (BT) @(negedge clk);
  endtask
  // Capture: each bit sampled mid-way
  always begin
    @(negedge txd);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk);
      sh[i] = txd;
    end
    got = sh;
    n_got++;
    repeat (BT) @(posedge clk);
  end
endmodule
`default_nettype wire

// ---- bench/rsp_port_bench.sv ----
// Bench for the serial port: scenarios driven at the falling edge
`default_nettype none
module rsp_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rsp_pkg::*;
  logic       clk, rst_n, cmd_valid, cmd_ready, cmd_done; // Clock, command
  rsp_cmd_t   cmd_code;                                   // Command code
  logic [7:0] cmd_arg, default_serial_config, stat_flags; // Values
  logic [7:0] stat_line_or_rx, stat_tx_count;             // Status
  logic [7:0] tx_data, rx_data;                           // Chars
  logic       tx_valid, tx_ready, rx_valid, rx_ready;     // Streams
  logic       receive_line_level, dsr_in, carrier_detect_in; // Pins in
  logic       txd_out, dtr_out, rts_out;                  // Pins out
  int         num_errors, num_checks, cyc;                // Tallies
  // 19200 baud gives 100 clocks a bit at this clock rate
  rsp_port #(.CLK_HZ(1_920_000)) u_dut (
    .clk, .rst_n, .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready, .cmd_done,
    .default_serial_config, .stat_flags, .stat_line_or_rx, .stat_tx_count,
    .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready,
    .receive_line_level, .dsr_in, .carrier_detect_in, .txd_out, .dtr_out, .rts_out);
  rsp_far_end #(.BT(100)) u_far (.clk, .txd(txd_out), .rxd(receive_line_level));
  //////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Command at a falling edge with ready high; waits for done
  task automatic cmd(input rsp_cmd_t c, input logic [7:0] a);
    int n;
    n = 0;
    cmd_code = c;
    cmd_arg = a;
    cmd_valid = 1'b1;
    // Hold the request until an edge sees ready high
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, cmd_done}, 8'h01);
    // Let an edge pass so the next request never re-raises valid in this step
    @(negedge clk);
  endtask
  task automatic t_open;
    cmd(CMD_OPEN, 8'h0c);
    chk({6'h0, dtr_out, rts_out}, 8'h03);
    chk({6'h0, cmd_ready, tx_ready}, 8'h03);
    cmd(CMD_RATE_STOP, 8'h0f);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_line_or_rx, 8'hf1);
    chk(stat_tx_count, 8'h00);
  endtask
  // Back-to-back chars, flush must wait for both
  task automatic t_tx;
    tx_data = 8'ha5;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_data = 8'h5a;
    @(negedge clk);
    tx_valid = 1'b0;
    cmd(CMD_FLUSH, 8'h00);
    chk(u_far.got, 8'h5a);
    chk(u_far.n_got[7:0], 8'h02);
  endtask
  task automatic t_dtr;
    cmd(CMD_LINE_CTL, 8'h80);
    chk({7'h0, dtr_out}, 8'h00);
    u_far.send(8'h3c, 1'b1);
    chk({7'h0, rx_valid}, 8'h00);
    cmd(CMD_LINE_CTL, 8'hc0);
    chk({7'h0, dtr_out}, 8'h01);
  endtask
  task automatic t_rx;
    u_far.send(8'h3c, 1'b1);
    chk(rx_data, 8'h3c);
    cmd(CMD_SET_CONC, 8'h00);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_line_or_rx, 8'h01);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    chk({7'h0, rx_valid}, 8'h00);
  endtask
  // Framing fault, history clear on read, reopen empties buffers
  task automatic t_err;
    u_far.send(8'h55, 1'b0);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_flags, 8'h80);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_flags, 8'h00);
    dsr_in = 1'b0;
    carrier_detect_in = 1'b1;
    cmd(CMD_OPEN, 8'h0c);
    chk({7'h0, rx_valid}, 8'h00);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_line_or_rx, 8'h3d);
    // Even parity from the stored default; far end sends no parity bit
    default_serial_config = 8'h10;
    cmd(CMD_OPEN, 8'h0c);
    u_far.send(8'h3c, 1'b1);
    cmd(CMD_STATUS, 8'h00);
    chk(stat_flags, 8'h20);
  endtask
  task automatic t_force;
    cmd(CMD_LINE_CTL, 8'h22);
    chk({6'h0, txd_out, rts_out}, 8'h00);
    cmd(CMD_LINE_CTL, 8'h33);
    chk({6'h0, txd_out, rts_out}, 8'h03);
    cmd(CMD_CLOSE, 8'h00);
    chk({6'h0, dtr_out, rts_out}, 8'h03);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst_n, cmd_valid, tx_valid, rx_ready, carrier_detect_in} = '0;
    {cmd_arg, tx_data, default_serial_config} = '0;
    cmd_code = CMD_STATUS;
    dsr_in = 1'b1;
    repeat (12) @(negedge clk);
    chk({3'h0, cmd_ready, tx_ready, txd_out, dtr_out, rts_out}, 8'h14);
    rst_n = 1'b1;
    @(negedge clk);
    t_open;
    t_tx;
    t_dtr;
    t_rx;
    t_err;
    t_force;
    close_out;
  end
  // Watchdog well above the roughly 7000 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      close_out;
    end
  end
endmodule
`default_nettype wire

// ---- hw/rsp_pkg.sv ----
// Shared constants and types for the serial port with line control
`default_nettype none
package rsp_pkg;
  // Clock and baud figures
  localparam int CLK_HZ_DEF = 40_000_000;  // System clock rate
  localparam int BAUD_110   = 110;
  localparam int BAUD_300   = 300;
  localparam int BAUD_600   = 600;
  localparam int BAUD_1200  = 1200;
  localparam int BAUD_2400  = 2400;
  localparam int BAUD_4800  = 4800;
  localparam int BAUD_9600  = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int DATA_BITS  = 8;           // Fixed word size
  // Open direction code bits
  localparam int DIR_RX_BIT = 2;
  localparam int DIR_TX_BIT = 3;
  // Line-control value bits
  localparam int LC_DTR_EN   = 7;
  localparam int LC_DTR_VAL  = 6;
  localparam int LC_RTS_EN   = 5;
  localparam int LC_RTS_VAL  = 4;
  localparam int LC_FORCE_EN = 1;
  localparam int LC_FORCE_VAL = 0;
  // Rate/stop value fields
  localparam int CFG_TWO_STOP = 7;
  localparam int CFG_RATE_LSB = 0;
  // Default config parity field
  localparam int DEF_PAR_LSB = 3;
  // Error history bits
  localparam int ERR_FRAME    = 7;
  localparam int ERR_OVERRUN  = 6;
  localparam int ERR_PARITY   = 5;
  localparam int ERR_OVERFLOW = 4;
  // Reset values
  localparam logic [3:0] RST_RATE  = 4'h0;
  localparam logic [1:0] RST_PAR   = 2'h0;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  // Parity modes
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK} rsp_par_t;
  // Host commands
  typedef enum logic [2:0] {
    CMD_OPEN, CMD_CLOSE, CMD_FLUSH, CMD_LINE_CTL, CMD_RATE_STOP, CMD_SET_CONC, CMD_STATUS
  } rsp_cmd_t;
endpackage
`default_nettype wire

// ---- hw/rsp_port.sv ----
// Serial port with buffered transmit and receive, error history and line control
`default_nettype none
module rsp_port
  import rsp_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF,  // Shorten to speed up simulation
  parameter int AW     = 8            // Buffer index width; holds 2**AW-1 chars
) (
  input  wire logic              clk,                   // System clock
  input  wire logic              rst_n,                 // Async reset, active low
  input  wire logic              cmd_valid,             // Command offered
  input  wire rsp_pkg::rsp_cmd_t cmd_code,              // Command
  input  wire logic [7:0]        cmd_arg,               // Command value
  output logic                   cmd_ready,             // Command taken
  output logic                   cmd_done,              // Pulse: command complete
  input  wire logic [7:0]        default_serial_config, // Stored default settings
  output logic [7:0]             stat_flags,            // Error history snapshot
  output logic [7:0]             stat_line_or_rx,       // Line byte or rx count
  output logic [7:0]             stat_tx_count,         // Tx count, zero in block mode
  input  wire logic              tx_valid,              // Outgoing char offered
  input  wire logic [7:0]        tx_data,               // Outgoing char
  output logic                   tx_ready,              // Outgoing char taken
  output logic                   rx_valid,              // Incoming char waiting
  output logic [7:0]             rx_data,               // Incoming char
  input  wire logic              rx_ready,              // Incoming char taken
  input  wire logic              receive_line_level,    // Serial in pin
  input  wire logic              dsr_in,                // DSR pin, high ready
  input  wire logic              carrier_detect_in,     // Carrier pin, high ready
  output logic                   txd_out,               // Serial out pin
  output logic                   dtr_out,               // DTR, high ready
  output logic                   rts_out                // RTS, high ready
);
  localparam logic [AW-1:0] FULL = {AW{1'b1}};

  typedef enum logic {ST_IDLE, ST_DRAIN} rsp_state_t;
  typedef struct packed {
    rsp_state_t  st;          // Command sequencer
    logic        done_r;      // Completion pulse
    logic        dtr_r;       // DTR level
    logic        rts_r;       // RTS level
    logic        force_en_r;  // Transmit line forced
    logic        force_val_r; // Forced level
    logic        conc_r;      // Concurrent-mode flag
    logic        rx_dir_r;    // Receive enabled by open
    logic        tx_dir_r;    // Transmit enabled by open
    logic        two_stop_r;  // Two stop bits
    logic [3:0]  rate_r;      // Baud code
    logic [1:0]  par_r;       // Parity mode
    logic [7:0]  flags_r;     // Error history
    logic [7:0]  sflags_r;    // Status snapshot
    logic [7:0]  sb1_r;       // Status byte one
    logic [7:0]  sb2_r;       // Status byte two
    logic [AW-1:0] rx_wp, rx_rp, rx_cnt;  // Receive buffer
    logic [AW-1:0] tx_wp, tx_rp, tx_cnt;  // Transmit buffer
    logic [2:0]  sync1;       // Pin sync stage one
    logic [2:0]  sync2;       // Pin sync stage two
  } rsp_st_t;
  rsp_st_t s, n;

  logic [7:0]  rx_mem [2**AW];  // Receive storage
  logic [7:0]  tx_mem [2**AW];  // Transmit storage
  logic [18:0] bit_cycles;
  logic        ser_tx_ready, ser_tx_busy, ser_txd, ser_rx_valid, ser_rx_ack;
  logic [7:0]  ser_rx_data;
  logic        fe, pe, ovr;
  logic        rx_push, rx_pop, tx_push, tx_pop, take;
  logic [7:0]  ev;
  logic [7:0]  line_byte;

  // Clocks per bit from the baud code; 19 bits so the slowest rate fits at full clock
  function automatic logic [18:0] cycles_of(input logic [3:0] code);
    unique case (code)
      4'd5:    cycles_of = 19'(CLK_HZ / BAUD_110);
      4'd9:    cycles_of = 19'(CLK_HZ / BAUD_600);
      4'd10:   cycles_of = 19'(CLK_HZ / BAUD_1200);
      4'd12:   cycles_of = 19'(CLK_HZ / BAUD_2400);
      4'd13:   cycles_of = 19'(CLK_HZ / BAUD_4800);
      4'd14:   cycles_of = 19'(CLK_HZ / BAUD_9600);
      4'd15:   cycles_of = 19'(CLK_HZ / BAUD_19200);
      default: cycles_of = 19'(CLK_HZ / BAUD_300);  // Codes 0, 8 and unsupported ones
    endcase
  endfunction
  assign bit_cycles = cycles_of(s.rate_r);

  ////////////////////////////////////////////////////////////////////
  // Handshakes and flow
  assign take       = cmd_valid && cmd_ready;
  assign cmd_ready  = (s.st == ST_IDLE);
  assign cmd_done   = s.done_r;
  assign tx_ready   = s.tx_dir_r && (s.tx_cnt != FULL);
  assign tx_push    = tx_valid && tx_ready;
  assign tx_pop     = (s.tx_cnt != '0) && ser_tx_ready;
  assign rx_valid   = (s.rx_cnt != '0);
  assign rx_data    = rx_mem[s.rx_rp];
  assign rx_pop     = rx_valid && rx_ready;
  // A full buffer leaves the char in the framer; the next one then overruns
  assign ser_rx_ack = ser_rx_valid && (!s.rx_dir_r || s.rx_cnt != FULL);
  assign rx_push    = ser_rx_ack && s.rx_dir_r;
  assign txd_out    = s.force_en_r ? s.force_val_r : ser_txd;
  assign dtr_out    = s.dtr_r;
  assign rts_out    = s.rts_r;
  assign stat_flags      = s.sflags_r;
  assign stat_line_or_rx = s.sb1_r;
  assign stat_tx_count   = s.sb2_r;

  // Line state: CTS and receive mark always shown ready
  assign line_byte = {s.sync2[1], s.sync2[1], 1'b1, 1'b1,
                      s.sync2[0], s.sync2[0], 1'b0, 1'b1};

  // Error events this cycle
  always_comb begin
    ev               = 8'h00;
    ev[ERR_FRAME]    = fe;
    ev[ERR_OVERRUN]  = ovr;
    ev[ERR_PARITY]   = pe;
    ev[ERR_OVERFLOW] = ser_rx_valid && s.rx_dir_r && (s.rx_cnt == FULL);
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n        = s;
    n.done_r = 1'b0;
    n.sync1  = {receive_line_level, dsr_in, carrier_detect_in};
    n.sync2  = s.sync1;
    // Buffer pointers; an open below overrides them
    n.rx_wp  = s.rx_wp + AW'(rx_push);
    n.rx_rp  = s.rx_rp + AW'(rx_pop);
    n.rx_cnt = s.rx_cnt + AW'(rx_push) - AW'(rx_pop);
    n.tx_wp  = s.tx_wp + AW'(tx_push);
    n.tx_rp  = s.tx_rp + AW'(tx_pop);
    n.tx_cnt = s.tx_cnt + AW'(tx_push) - AW'(tx_pop);
    // New errors win over a clear by status
    n.flags_r = s.flags_r | ev;
    unique case (s.st)
      ST_IDLE: begin
        if (take) begin
          unique case (cmd_code)
            CMD_OPEN: begin
              n.rx_wp  = '0;
              n.rx_rp  = '0;
              n.rx_cnt = '0;
              n.tx_wp  = '0;
              n.tx_rp  = '0;
              n.tx_cnt = '0;
              n.dtr_r  = 1'b1;
              n.rts_r  = 1'b1;
              n.conc_r = 1'b0;
              n.rx_dir_r = cmd_arg[DIR_RX_BIT];
              n.tx_dir_r = cmd_arg[DIR_TX_BIT];
              n.par_r  = default_serial_config[DEF_PAR_LSB +: 2];
              n.done_r = 1'b1;
            end
            // Both wait for the transmit side to empty; nothing else changes
            CMD_CLOSE, CMD_FLUSH: begin
              n.st = ST_DRAIN;
            end
            CMD_LINE_CTL: begin
              if (cmd_arg[LC_DTR_EN]) begin
                n.dtr_r = cmd_arg[LC_DTR_VAL];
              end
              if (cmd_arg[LC_RTS_EN]) begin
                n.rts_r = cmd_arg[LC_RTS_VAL];
              end
              if (cmd_arg[LC_FORCE_EN]) begin
                n.force_val_r = cmd_arg[LC_FORCE_VAL];
              end
              n.force_en_r = cmd_arg[LC_FORCE_EN];  // Clear bit releases the line
              n.done_r = 1'b1;
            end
            CMD_RATE_STOP: begin
              n.two_stop_r = cmd_arg[CFG_TWO_STOP];
              n.rate_r     = cmd_arg[CFG_RATE_LSB +: 4];
              n.done_r     = 1'b1;
            end
            CMD_SET_CONC: begin
              n.conc_r = 1'b1;
              n.done_r = 1'b1;
            end
            CMD_STATUS: begin
              n.sflags_r = s.flags_r | ev;
              n.flags_r  = ev;
              n.sb1_r    = s.conc_r ? 8'(s.rx_cnt) : line_byte;
              n.sb2_r    = s.conc_r ? 8'(s.tx_cnt) : 8'h00;
              n.done_r   = 1'b1;
            end
            default: begin
              n.done_r = 1'b1;  // Unused code: acknowledge only
            end
          endcase
        end
      end
      ST_DRAIN: begin
        // Completes once the last stop bit is out; stalls while DTR is false and chars remain buffered
        if (s.tx_cnt == '0 && !ser_tx_busy) begin
          n.st     = ST_IDLE;
          n.done_r = 1'b1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: ST_IDLE, done_r: 1'b0, dtr_r: 1'b0, rts_r: 1'b0, force_en_r: 1'b0,
             force_val_r: 1'b1, conc_r: 1'b0, rx_dir_r: 1'b0, tx_dir_r: 1'b0,
             two_stop_r: 1'b0, rate_r: RST_RATE, par_r: RST_PAR, flags_r: RST_FLAGS,
             sflags_r: RST_FLAGS, sb1_r: 8'h00, sb2_r: 8'h00, rx_wp: '0, rx_rp: '0,
             rx_cnt: '0, tx_wp: '0, tx_rp: '0, tx_cnt: '0, sync1: 3'h7, sync2: 3'h7};
    end else begin
      s <= n;
    end
  end

  // Buffer storage, no reset needed
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[s.rx_wp] <= ser_rx_data;
    end
    if (tx_push) begin
      tx_mem[s.tx_wp] <= tx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Framer
  rsp_serdes u_serdes (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (s.dtr_r),
    .bit_cycles(bit_cycles),
    .two_stop  (s.two_stop_r),
    .par_mode  (s.par_r),
    .tx_valid  (s.tx_cnt != '0),
    .tx_data   (tx_mem[s.tx_rp]),
    .tx_ready  (ser_tx_ready),
    .tx_busy   (ser_tx_busy),
    .txd       (ser_txd),
    .rxd       (s.sync2[2]),
    .rx_valid  (ser_rx_valid),
    .rx_data   (ser_rx_data),
    .rx_ack    (ser_rx_ack),
    .frame_err (fe),
    .par_err   (pe),
    .overrun   (ovr)
  );

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  open_clears_a: assert property (take && cmd_code == CMD_OPEN
    |=> dtr_out && rts_out && !rx_valid && !s.conc_r) else $error("open state wrong");
  halt_tx_a: assert property (!dtr_out && !ser_tx_busy |=> !ser_tx_busy)
    else $error("sent while halted");
  close_wait_a: assert property (s.st == ST_DRAIN && s.tx_cnt != '0
    |=> !cmd_done) else $error("close done early");
  close_keep_a: assert property (take && cmd_code == CMD_CLOSE
    |=> $stable({dtr_out, rts_out, s.rate_r, s.two_stop_r})) else $error("close changed");
  block_line_a: assert property (take && cmd_code == CMD_STATUS && !s.conc_r
    |=> stat_line_or_rx[0] && stat_line_or_rx[5] && stat_line_or_rx[4]
        && stat_line_or_rx[6] == stat_line_or_rx[7]
        && stat_line_or_rx[2] == stat_line_or_rx[3]) else $error("line byte wrong");
  conc_count_a: assert property (take && cmd_code == CMD_STATUS && s.conc_r
    |=> stat_line_or_rx == 8'($past(s.rx_cnt))
        && stat_tx_count == 8'($past(s.tx_cnt))) else $error("counts wrong");
  dtr_ctl_a: assert property (take && cmd_code == CMD_LINE_CTL && cmd_arg[LC_DTR_EN]
    |=> dtr_out == $past(cmd_arg[LC_DTR_VAL])) else $error("dtr not set");
  rts_ctl_a: assert property (take && cmd_code == CMD_LINE_CTL && cmd_arg[LC_RTS_EN]
    |=> rts_out == $past(cmd_arg[LC_RTS_VAL])) else $error("rts not set");
  force_ctl_a: assert property (take && cmd_code == CMD_LINE_CTL && cmd_arg[LC_FORCE_EN]
    |=> txd_out == $past(cmd_arg[LC_FORCE_VAL])) else $error("line not forced");
  rate_set_a: assert property (take && cmd_code == CMD_RATE_STOP
    |=> s.rate_r == $past(cmd_arg[3:0]) && s.two_stop_r == $past(cmd_arg[7]))
    else $error("rate not set");
  overflow_a: assert property (ev[ERR_OVERFLOW] |=> s.flags_r[ERR_OVERFLOW])
    else $error("overflow lost");
  frame_flag_a: assert property (fe |=> s.flags_r[ERR_FRAME]) else $error("frame lost");
  status_clr_a: assert property (take && cmd_code == CMD_STATUS
    |=> s.flags_r == $past(ev)) else $error("history not cleared");

  open_cov_c:     cover property (take && cmd_code == CMD_OPEN);
  drain_cov_c:    cover property (s.st == ST_DRAIN ##1 s.st == ST_IDLE);
  conc_stat_c:    cover property (take && cmd_code == CMD_STATUS && s.conc_r);
  overflow_cov_c: cover property (ev[ERR_OVERFLOW]);
endmodule
`default_nettype wire

// ---- hw/rsp_serdes.sv ----
// Character framer: one transmitter and one receiver at a shared bit time
`default_nettype none
module rsp_serdes
  import rsp_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst_n,        // Async reset, active low
  input  wire logic        enable,       // Low halts new frames
  input  wire logic [18:0] bit_cycles,   // Clocks per bit
  input  wire logic        two_stop,     // Two stop bits on send
  input  wire logic [1:0]  par_mode,     // Parity mode
  input  wire logic        tx_valid,     // Char offered
  input  wire logic [7:0]  tx_data,      // Char to send
  output logic             tx_ready,     // Char taken
  output logic             tx_busy,      // Frame in progress
  output logic             txd,          // Serial out, idle high
  input  wire logic        rxd,          // Serial in, synchronised
  output logic             rx_valid,     // Char held
  output logic [7:0]       rx_data,      // Held char
  input  wire logic        rx_ack,       // Holder emptied
  output logic             frame_err,    // Pulse: bad stop bit
  output logic             par_err,      // Pulse: bad parity
  output logic             overrun       // Pulse: held char lost
);
  typedef struct packed {
    logic [18:0] tx_cnt;   // Bit timer
    logic [3:0]  tx_left;  // Bits still to shift
    logic [11:0] tx_sh;    // Frame shifter
    logic        txd_r;    // Line level
    logic [18:0] rx_cnt;   // Sample timer
    logic [3:0]  rx_left;  // Samples still due
    logic [10:0] rx_sh;    // Sample shifter
    logic        rx_val_r; // Holder full
    logic [7:0]  rx_dat_r; // Holder
    logic [2:0]  err_r;    // Frame, parity, overrun
  } rsp_ser_t;
  rsp_ser_t s, n;
  logic par_on;
  logic par_bit;

  assign par_on    = (par_mode != PAR_NONE);
  assign tx_busy   = (s.tx_left != 4'h0);
  assign tx_ready  = enable && !tx_busy;  // Halted while DTR is false
  assign txd       = s.txd_r;
  assign rx_valid  = s.rx_val_r;
  assign rx_data   = s.rx_dat_r;
  assign frame_err = s.err_r[2];
  assign par_err   = s.err_r[1];
  assign overrun   = s.err_r[0];

  // Parity bit for a given data byte
  function automatic logic par_of(input logic [7:0] d);
    unique case (par_mode)
      PAR_ODD:  par_of = ~^d;
      PAR_EVEN: par_of = ^d;
      default:  par_of = 1'b1;
    endcase
  endfunction
  assign par_bit = par_of(tx_data);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = s;
    n.err_r = 3'h0;
    if (rx_ack) begin
      n.rx_val_r = 1'b0;
    end
    // Transmit: start, 8 data, optional parity, 1 or 2 stops
    if (tx_valid && tx_ready) begin
      n.tx_cnt  = bit_cycles;
      n.tx_left = 4'd10 + {3'h0, par_on} + {3'h0, two_stop};
      n.tx_sh   = par_on ? {2'b11, par_bit, tx_data, 1'b0} : {3'b111, tx_data, 1'b0};
    end else if (tx_busy) begin
      if (s.tx_cnt <= 19'd1) begin
        n.tx_cnt  = bit_cycles;
        n.tx_left = s.tx_left - 4'h1;
        n.tx_sh   = {1'b1, s.tx_sh[11:1]};
      end else begin
        n.tx_cnt = s.tx_cnt - 19'd1;
      end
    end
    n.txd_r = (n.tx_left != 4'h0) ? n.tx_sh[0] : 1'b1;
    // Receive: centre sampling, start checked, one stop checked
    if (s.rx_left == 4'h0) begin
      if (enable && !rxd) begin
        n.rx_cnt  = {1'b0, bit_cycles[18:1]};
        n.rx_left = 4'd10 + {3'h0, par_on};
      end
    end else if (s.rx_cnt <= 19'd1) begin
      n.rx_cnt  = bit_cycles;
      n.rx_sh   = {rxd, s.rx_sh[10:1]};
      n.rx_left = s.rx_left - 4'h1;
      // False start: line back high at the centre of the start bit
      if (rxd && (s.rx_left == 4'd10 + {3'h0, par_on})) begin
        n.rx_left = 4'h0;
      end else if (s.rx_left == 4'h1) begin
        n.rx_val_r = 1'b1;
        n.rx_dat_r = par_on ? n.rx_sh[8:1] : n.rx_sh[9:2];
        n.err_r[2] = !rxd;
        n.err_r[1] = par_on && (n.rx_sh[9] != par_of(n.rx_sh[8:1]));
        n.err_r[0] = s.rx_val_r && !rx_ack;  // Holder never emptied
      end
    end else begin
      n.rx_cnt = s.rx_cnt - 19'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{tx_cnt: 19'h0, tx_left: 4'h0, tx_sh: 12'hfff, txd_r: 1'b1, rx_cnt: 19'h0,
             rx_left: 4'h0, rx_sh: 11'h0, rx_val_r: 1'b0, rx_dat_r: 8'h00, err_r: 3'h0};
    end else begin
      s <= n;
    end
  end

  // Assertions
  start_bit_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_valid && tx_ready |=> !txd && tx_busy) else $error("no start bit");
  halt_no_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enable && s.rx_left == 4'h0 |=> s.rx_left == 4'h0) else $error("rx ran halted");
endmodule
`default_nettype wire
